/* adcs_defs.svh */
// Purpose: Constants for the converter control and status block
// Assumes: APB byte addresses, 32-bit data, 8-bit registers in low bits
// Notes: Offsets D1h-D3h not multiples of four, so they are register indices
`ifndef ADCS_DEFS_SVH
`define ADCS_DEFS_SVH

// ==========================================================================
// Register indices and byte addresses
`define ADCS_IDX_RESULT 8'h00D0
`define ADCS_IDX_CTRL 8'h00D1
`define ADCS_IDX_IRQ_STAT 8'h00D2
`define ADCS_IDX_IRQ_MASK 8'h00D3
`define ADCS_ADDR_W 12
`define ADCS_ADDR_RESULT 12'h0340
`define ADCS_ADDR_CTRL 12'h0344
`define ADCS_ADDR_IRQ_STAT 12'h0348
`define ADCS_ADDR_IRQ_MASK 12'h034C

// ==========================================================================
// Control register fields and reset
`define ADCS_BIT_IRQ_EN 7
`define ADCS_BIT_DONE 6
`define ADCS_BIT_START 5
`define ADCS_BIT_PWR 4
`define ADCS_BIT_OSC_OFF 2
`define ADCS_CTRL_RESET 8'h40
`define ADCS_RESULT_RESET 8'h00

// ==========================================================================
// Timing: one approximation trial per this many clocks
`define ADCS_TRIAL_CYCLES 4'h4
`define ADCS_TRIALS 4'h8

`endif

/* adcs_pkg.sv */
// Purpose: Types for the converter control and status block
// Assumes: Constants live in adcs_defs.svh
// Notes: Gray coded sequencer states
package adcs_pkg;
  typedef enum logic [1:0] {
    ADCS_OFF = 2'b00,
    ADCS_IDLE = 2'b01,
    ADCS_CONV = 2'b11
  } adcs_state_t;
  typedef logic [7:0] adcs_byte_t;
endpackage

/* adcs_sync.sv */
// Purpose: Two-flop synchroniser for pin-level inputs
// Assumes: Inputs asynchronous to clk
// Notes: First stage read only by the second
`timescale 1ns/1ps
`default_nettype none
module adcs_sync #(
  parameter int W = 1
) (
  input wire logic clk,            // Core clock
  input wire logic rst,            // Sync reset, high
  input wire logic [W-1:0] d,      // Asynchronous level
  output logic [W-1:0] q           // Synchronised level
);
  logic [W-1:0] meta;
  logic [W-1:0] next_meta;
  logic [W-1:0] next_q;

  // ==========================================================================
  // Next values
  always_comb begin
    next_meta = d;
    next_q = meta;
  end

  // Two stages, cleared at reset
  always_ff @(posedge clk) begin
    if (rst) begin
      meta <= '0;
      q <= '0;
    end else begin
      meta <= next_meta;
      q <= next_q;
    end
  end
endmodule
`default_nettype wire

/* adcs_sar.sv */
// Purpose: Successive-approximation trial sequencer
// Assumes: Comparator answer valid half a trial period (two clocks) after dac code changes
// Notes: Restart abandons the running conversion
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_sar (
  input wire logic clk,                     // Core clock
  input wire logic rst,                     // Sync reset, high
  input wire logic start,                   // One-cycle start pulse
  input wire logic enable,                  // Powered and not stopped
  input wire logic cmp_above,               // Input above trial code, synced
  output adcs_pkg::adcs_byte_t dac_code,    // Trial code to the ladder
  output logic busy,                        // Conversion running
  output logic done,                        // One-cycle finish pulse
  output adcs_pkg::adcs_byte_t result       // Final code, valid with done
);
  import adcs_pkg::*;
  logic [3:0] tick;
  logic [3:0] next_tick;
  logic [2:0] bit_idx;
  logic [2:0] next_bit_idx;
  adcs_byte_t next_dac_code;
  logic next_busy;
  logic next_done;
  adcs_byte_t next_result;
  adcs_byte_t trial;

  // ==========================================================================
  // Trial stepping, MSB first; final trial loads result
  always_comb begin
    next_tick = tick;
    next_bit_idx = bit_idx;
    next_dac_code = dac_code;
    next_busy = busy;
    next_done = 1'b0;
    next_result = result;
    trial = dac_code;
    if (!cmp_above) begin
      trial[bit_idx] = 1'b0;
    end
    if (!enable) begin
      next_busy = 1'b0;
    end else if (start) begin // Restart wins over a running one [RULE11]
      next_busy = 1'b1;
      next_tick = 4'h0;
      next_bit_idx = 3'd7;
      next_dac_code = 8'h80;
    end else if (busy) begin
      next_tick = tick + 4'h1;
      if (tick == `ADCS_TRIAL_CYCLES - 4'h1) begin
        next_tick = 4'h0;
        if (bit_idx == 3'd0) begin // [RULE18]
          next_busy = 1'b0;
          next_done = 1'b1;
          next_result = trial; // Saturates to 00h or FFh at rails [RULE16]
          next_dac_code = trial;
        end else begin
          next_bit_idx = bit_idx - 3'd1;
          next_dac_code = trial | (8'h01 << (bit_idx - 3'd1));
        end
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      tick <= 4'h0;
      bit_idx <= 3'd7;
      dac_code <= 8'h00;
      busy <= 1'b0;
      done <= 1'b0;
      result <= `ADCS_RESULT_RESET;
    end else begin
      tick <= next_tick;
      bit_idx <= next_bit_idx;
      dac_code <= next_dac_code;
      busy <= next_busy;
      done <= next_done;
      result <= next_result;
    end
  end
endmodule
`default_nettype wire

/* adcs_top.sv */
// Purpose: Converter control/status registers behind APB, with sequencer
// Assumes: Comparator and stop-mode request arrive from other clock domains
// Notes: Sequencer in adcs_sar, pin inputs synchronised in adcs_sync
// Operation
// RULE1: Runs in wait, wakes core; off in stop
// RULE2: Power bit 4 switches converter on/off
// RULE3: Zero writes never clear done flag
// RULE4: Handler should clear interrupt enable itself
// RULE5: Control at D1h, resets 40h, mixed access
// RULE6: Bit 7 gates converter interrupt request
// RULE7: Finish sets done flag, raises enabled request
// RULE8: Start write clears done and pending request
// RULE9: Result valid only while done reads one
// RULE10: Bit 5 write one starts conversion
// RULE11: Restart abandons running conversion immediately
// RULE12: Start bit always reads zero
// RULE13: Software writes zero to reserved bits
// RULE14: Bit 2 drives main oscillator disable only
// RULE15: Result read-only at D0h, MSB bit 7
// RULE16: Rails give FFh and 00h results
// RULE17: Power on before start, separate writes
// RULE18: Eight MSB-first trials, load on last
//
// Chosen here: register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_top (
  input wire logic clk,                         // Core clock, 40 MHz
  input wire logic rst,                         // Sync reset, high
  input wire logic [`ADCS_ADDR_W-1:0] paddr,    // APB address
  input wire logic psel,                        // APB select
  input wire logic penable,                     // APB access phase
  input wire logic pwrite,                      // APB direction
  input wire logic [31:0] pwdata,               // APB write data
  input wire logic [3:0] pstrb,                 // APB byte strobes
  output logic [31:0] prdata,                   // APB read data
  output logic pready,                          // APB ready
  output logic pslverr,                         // APB error
  input wire logic cmp_above_pin,               // Comparator, async
  input wire logic stop_mode_pin,               // Stop mode request, async
  output adcs_pkg::adcs_byte_t dac_code,        // Ladder trial code
  output logic converter_power_on,              // Analog power enable
  output logic main_osc_disable,                // Main oscillator off
  output logic conv_irq,                        // Converter request to core
  output logic wake_req,                        // Wait-mode wake request
  output logic irq                              // Masked status interrupt
);
  import adcs_pkg::*;

  // ==========================================================================
  // Register selector codes from the address decode
  localparam logic [2:0] SEL_NONE = 3'h0;
  localparam logic [2:0] SEL_RESULT = 3'h1;
  localparam logic [2:0] SEL_CTRL = 3'h2;
  localparam logic [2:0] SEL_STAT = 3'h3;
  localparam logic [2:0] SEL_MASK = 3'h4;

  // ==========================================================================
  // Address decode, used by read and write paths
  function automatic logic [2:0] reg_sel(input logic [`ADCS_ADDR_W-1:0] a);
    case (a)
      `ADCS_ADDR_RESULT: reg_sel = SEL_RESULT;
      `ADCS_ADDR_CTRL: reg_sel = SEL_CTRL;
      `ADCS_ADDR_IRQ_STAT: reg_sel = SEL_STAT;
      `ADCS_ADDR_IRQ_MASK: reg_sel = SEL_MASK;
      default: reg_sel = SEL_NONE;
    endcase
  endfunction

  logic cmp_above;
  logic stop_mode;
  logic [`ADCS_ADDR_W-1:0] paddr_q;
  logic irq_enable;
  logic done_flag;
  logic osc_off;
  logic pwr_on;
  logic [2:0] ctl_reserved;
  logic [1:0] irq_stat;
  logic [1:0] irq_mask;
  adcs_state_t state;
  logic next_irq_enable;
  logic next_done_flag;
  logic next_osc_off;
  logic next_pwr_on;
  logic [2:0] next_ctl_reserved;
  logic [1:0] next_irq_stat;
  logic [1:0] next_irq_mask;
  adcs_state_t next_state;
  logic [31:0] next_prdata;
  logic next_pready;
  logic next_pslverr;
  logic next_conv_irq;
  logic next_wake_req;
  logic next_irq;
  logic next_converter_power_on;
  logic next_main_osc_disable;
  logic wr_acc;
  logic rd_acc;
  logic [2:0] sel;
  logic start_pulse;
  logic conv_enable;
  logic sar_busy;
  logic sar_done;
  adcs_byte_t sar_result;
  adcs_byte_t ctrl_rd;
  adcs_byte_t wbyte;

  // ==========================================================================
  // Pin inputs pass two flops
  adcs_sync #(.W(2)) u_sync (
    .clk(clk),
    .rst(rst),
    .d({cmp_above_pin, stop_mode_pin}),
    .q({cmp_above, stop_mode})
  );

  // Converter runs only when powered and not in stop
  assign conv_enable = pwr_on && !stop_mode; // [RULE1] [RULE2]

  adcs_sar u_sar (
    .clk(clk),
    .rst(rst),
    .start(start_pulse),
    .enable(conv_enable),
    .cmp_above(cmp_above),
    .dac_code(dac_code),
    .busy(sar_busy),
    .done(sar_done),
    .result(sar_result)
  );

  // ==========================================================================
  // APB access qualification; one wait state so pready is registered
  assign sel = reg_sel(paddr);
  assign wr_acc = psel && penable && pwrite && pready;
  assign rd_acc = psel && penable && !pwrite && !pready;
  assign wbyte = pstrb[0] ? pwdata[7:0] : 8'h00;
  assign start_pulse = wr_acc && pstrb[0] && (reg_sel(paddr_q) == SEL_CTRL)
                       && pwdata[`ADCS_BIT_START] && conv_enable; // [RULE10]

  // Control read image; start always zero
  always_comb begin
    ctrl_rd = 8'h00;
    ctrl_rd[`ADCS_BIT_IRQ_EN] = irq_enable;
    ctrl_rd[`ADCS_BIT_DONE] = done_flag;
    ctrl_rd[`ADCS_BIT_START] = 1'b0; // [RULE12]
    ctrl_rd[`ADCS_BIT_PWR] = pwr_on;
    ctrl_rd[3] = ctl_reserved[2];
    ctrl_rd[`ADCS_BIT_OSC_OFF] = osc_off;
    ctrl_rd[1:0] = ctl_reserved[1:0];
  end

  // ==========================================================================
  // Register and flag next values
  always_comb begin
    next_irq_enable = irq_enable;
    next_done_flag = done_flag;
    next_osc_off = osc_off;
    next_pwr_on = pwr_on;
    next_ctl_reserved = ctl_reserved;
    next_irq_mask = irq_mask;
    next_irq_stat = irq_stat;
    if (wr_acc && pstrb[0]) begin
      case (reg_sel(paddr_q))
        SEL_CTRL: begin // Done bit is read only [RULE5]
          next_irq_enable = wbyte[`ADCS_BIT_IRQ_EN]; // [RULE6]
          next_pwr_on = wbyte[`ADCS_BIT_PWR];
          next_osc_off = wbyte[`ADCS_BIT_OSC_OFF]; // [RULE14]
          next_ctl_reserved = {wbyte[3], wbyte[1:0]};
        end
        SEL_STAT: next_irq_stat = irq_stat & ~wbyte[1:0];
        SEL_MASK: next_irq_mask = wbyte[1:0];
        default: next_irq_stat = irq_stat;
      endcase
    end
    // Start clears done; zero writes leave it alone [RULE3] [RULE8]
    if (start_pulse) begin
      next_done_flag = 1'b0;
    end
    // Finish sets done; set wins over any clear [RULE7] [RULE9]
    if (sar_done) begin
      next_done_flag = 1'b1;
      next_irq_stat[0] = 1'b1;
    end
    if (start_pulse) begin
      next_irq_stat[1] = 1'b1; // Every start event logged too
    end
  end

  // ==========================================================================
  // Sequencer view: off, idle or converting
  // Gray path, one bit flips per step except CONV to OFF, which flips both
  always_comb begin
    case (state)
      ADCS_OFF: next_state = conv_enable ? ADCS_IDLE : ADCS_OFF;
      ADCS_IDLE: next_state = !conv_enable ? ADCS_OFF :
                              (start_pulse ? ADCS_CONV : ADCS_IDLE);
      ADCS_CONV: next_state = !conv_enable ? ADCS_OFF :
                              (sar_busy || start_pulse ? ADCS_CONV : ADCS_IDLE);
      default: next_state = ADCS_OFF;
    endcase
  end

  // ==========================================================================
  // Bus answer: one wait state, read image taken while pready is low
  always_comb begin
    // Writes answer alike; the write lands at the pready edge
    next_pready = rd_acc || (psel && penable && pwrite && !pready);
    next_pslverr = 1'b0;
    next_prdata = 32'h0000_0000;
    if (psel && penable && !pready) begin
      // Unmapped offsets answer with error and zero data, no write
      next_pslverr = (sel == SEL_NONE);
      case (sel)
        SEL_RESULT: next_prdata = {24'h00_0000, sar_result}; // [RULE15]
        SEL_CTRL: next_prdata = {24'h00_0000, ctrl_rd};
        SEL_STAT: next_prdata = {30'h0000_0000, irq_stat};
        SEL_MASK: next_prdata = {30'h0000_0000, irq_mask};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end

  // ==========================================================================
  // Output levels from next values, so they change at the write edge
  always_comb begin
    // Request held while done and enabled; handler clears enable [RULE4] [RULE7]
    next_conv_irq = next_done_flag && next_irq_enable;
    // Stop mode blocks wake since converter is off there [RULE1]
    next_wake_req = next_conv_irq && !stop_mode;
    next_irq = |(next_irq_stat & next_irq_mask);
    // Power pin drops in stop whatever the power bit holds
    next_converter_power_on = next_pwr_on && !stop_mode; // [RULE2]
    next_main_osc_disable = next_osc_off; // Clock system only [RULE14]
  end

  // ==========================================================================
  // Bus registers; address latched every clock, used at the write edge
  always_ff @(posedge clk) begin
    if (rst) begin
      paddr_q <= '0;
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else begin
      paddr_q <= paddr;
      prdata <= next_prdata;
      pready <= next_pready;
      pslverr <= next_pslverr;
    end
  end

  // ==========================================================================
  // Control fields and flags; done set to match the 40h reset image
  always_ff @(posedge clk) begin
    if (rst) begin
      irq_enable <= 1'b0;
      done_flag <= 1'b1;
      osc_off <= 1'b0;
      pwr_on <= 1'b0;
      ctl_reserved <= 3'b000;
      irq_stat <= 2'b00;
      irq_mask <= 2'b00;
    end else begin
      irq_enable <= next_irq_enable;
      done_flag <= next_done_flag;
      osc_off <= next_osc_off;
      pwr_on <= next_pwr_on;
      ctl_reserved <= next_ctl_reserved;
      irq_stat <= next_irq_stat;
      irq_mask <= next_irq_mask;
    end
  end

  // ==========================================================================
  // Sequencer view register
  always_ff @(posedge clk) begin
    if (rst) begin
      state <= ADCS_OFF;
    end else begin
      state <= next_state;
    end
  end

  // ==========================================================================
  // Output flops: no pin sees a decode glitch
  // They also hold the request steady for the core
  always_ff @(posedge clk) begin
    if (rst) begin
      conv_irq <= 1'b0;
      wake_req <= 1'b0;
      irq <= 1'b0;
      converter_power_on <= 1'b0;
      main_osc_disable <= 1'b0;
    end else begin
      conv_irq <= next_conv_irq;
      wake_req <= next_wake_req;
      irq <= next_irq;
      converter_power_on <= next_converter_power_on;
      main_osc_disable <= next_main_osc_disable;
    end
  end
endmodule
`default_nettype wire

/* adcs_checker.sv */
// Purpose: Port assertions for adcs_top
// Assumes: One clock, sync reset high
// Notes: Bound to every adcs_top instance
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"
module adcs_checker (
  input wire logic clk, // Clock
  input wire logic rst, // Reset
  input wire logic [`ADCS_ADDR_W-1:0] paddr, // Address
  input wire logic psel, // Select
  input wire logic penable, // Access
  input wire logic pwrite, // Direction
  input wire logic [31:0] pwdata, // Write data
  input wire logic [31:0] prdata, // Read data
  input wire logic pready, // Ready
  input wire logic pslverr, // Error
  input wire logic stop_mode_pin, // Stop
  input wire logic converter_power_on, // Power
  input wire logic main_osc_disable, // Osc off
  input wire logic conv_irq, // Request
  input wire logic wake_req // Wake
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  logic wr;
  logic run;
  logic next_run;
  logic [7:0] cnt;
  logic [7:0] next_cnt;
  // ==========================================
  // Cycles since a powered start with request on
  assign wr = psel & penable & pready & pwrite & (paddr == `ADCS_ADDR_CTRL);
  // Any control write restarts the count
  always_comb begin
    next_run = run & ~conv_irq;
    next_cnt = cnt + 8'h01;
    if (wr) begin
      next_run = pwdata[5] & pwdata[7] & converter_power_on;
      next_cnt = 8'h00;
    end
  end
  always_ff @(posedge clk) begin
    if (rst) begin
      run <= 1'b0;
      cnt <= 8'h00;
    end else begin
      run <= next_run;
      cnt <= next_cnt;
    end
  end
  // ==========================================
  // Register access
  a_pready_pulse: assert property (pready |=> !pready)
    else $error("pready held");
  a_err_no_data: assert property (pready && pslverr |-> prdata == 32'h0000_0000)
    else $error("data on error");
  a_upper_zero: assert property (pready && !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("upper bits set");
  a_start_reads_0: assert property (pready && !pwrite && paddr == `ADCS_ADDR_CTRL
    |-> !prdata[5]) else $error("start bit read as one");
  // Outputs settle one cycle after a control write; checked two cycles after
  a_osc_follows: assert property (wr |=> ##1 main_osc_disable == $past(pwdata[2], 2))
    else $error("osc disable wrong");
  a_power_off: assert property (wr && !pwdata[4] |=> ##1 !converter_power_on)
    else $error("power stayed on");
  a_irq_gated: assert property (wr && !pwdata[7] |=> ##1 !conv_irq)
    else $error("request not gated");
  a_start_clears: assert property (wr && pwdata[5] && converter_power_on |=> ##1 !conv_irq)
    else $error("start kept request");
  // ==========================================
  // Conversion length and stop mode
  a_conv_not_early: assert property (run && conv_irq |-> cnt >= 8'h1e)
    else $error("conversion too short");
  a_conv_not_late: assert property (run |-> cnt <= 8'h26)
    else $error("conversion too long");
  a_stop_off: assert property (stop_mode_pin [*5] |-> !converter_power_on && !wake_req)
    else $error("active in stop");
endmodule
bind adcs_top adcs_checker u_chk (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata,
  .prdata, .pready, .pslverr, .stop_mode_pin, .converter_power_on, .main_osc_disable,
  .conv_irq, .wake_req);
`default_nettype wire

/* test_adc_control_status.sv */
// Purpose: Register level test of adcs_top
// Assumes: One wait state APB slave
// Notes: Tasks end at a falling edge so outputs are settled
`timescale 1ns/1ps
`default_nettype none
`include "adcs_defs.svh"
module test_adc_control_status;
  import adcs_pkg::*;
  localparam logic [11:0] CTL = `ADCS_ADDR_CTRL;
  localparam logic [11:0] RES = `ADCS_ADDR_RESULT;
  localparam logic [11:0] STS = `ADCS_ADDR_IRQ_STAT;
  localparam logic [11:0] MSK = `ADCS_ADDR_IRQ_MASK;
  logic clk, rst, psel, penable, pwrite, pready, pslverr, irq;
  logic cmp_above_pin, stop_mode_pin, converter_power_on, main_osc_disable, conv_irq, wake_req;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [3:0] pstrb;
  adcs_byte_t dac_code;
  int failures, samples_checked;
  adcs_top u_dut (.clk, .rst, .paddr, .psel, .penable, .pwrite, .pwdata, .pstrb, .prdata,
    .pready, .pslverr, .cmp_above_pin, .stop_mode_pin, .dac_code, .converter_power_on,
    .main_osc_disable, .conv_irq, .wake_req, .irq);
  // ==========================================
  // Clock and checking
  initial begin
    clk = 1'b0;
    forever begin
      #12.5 clk = ~clk;
    end
  end
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp) begin
      failures++;
      $display("wrong value %s: expected %h, seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("comparisons %0d, mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // ==========================================
  // Bus tasks; the wait ends on pready, or the watchdog ends the run
  task automatic apb(input logic [11:0] a, input logic w, input logic [31:0] d,
      output logic [31:0] q, output logic e);
    @(posedge clk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    // Values read right after the edge are the sampled ones
    do begin
      @(posedge clk);
    end while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    repeat (2) @(negedge clk);
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(a, 1'b1, d, q, e);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp, input string what);
    logic [31:0] q;
    logic e;
    apb(a, 1'b0, 32'h0000_0000, q, e);
    chk(what, exp, q);
  endtask
  // Falling edges until the request rises
  task automatic wait_irq(output int n);
    n = 0;
    do begin
      @(negedge clk);
      n++;
    end while (conv_irq !== 1'b1 && n < 60);
  endtask
  // Hang guard, far beyond the expected run
  initial begin
    repeat (3000) @(posedge clk);
    failures++;
    tally_and_finish();
  end
  // ==========================================
  // Scenarios
  initial begin
    int n;
    logic [31:0] q;
    logic e;
    failures = 0;
    samples_checked = 0;
    rst <= 1'b1;
    {psel, penable, pwrite, cmp_above_pin, stop_mode_pin} <= 5'h00;
    paddr <= 12'h000;
    pwdata <= 32'h0000_0000;
    pstrb <= 4'hf;
    repeat (5) @(posedge clk);
    rst <= 1'b0;
    rd(CTL, 32'h0000_0040, "control reset");
    rd(RES, 32'h0000_0000, "result reset");
    apb(12'h03f0, 1'b0, 32'h0000_0000, q, e);
    chk("unmapped error", 1'b1, e);
    chk("unmapped data", 32'h0000_0000, q);
    wr(RES, 32'h0000_00a5);
    rd(RES, 32'h0000_0000, "result read only");
    // Power up first; zero start and done bits change nothing
    wr(CTL, 32'h0000_0014);
    rd(CTL, 32'h0000_0054, "powered");
    chk("osc disable", 1'b1, main_osc_disable);
    chk("power", 1'b1, converter_power_on);
    // Full scale conversion, oscillator bit left set
    @(posedge clk);
    cmp_above_pin <= 1'b1;
    wr(CTL, 32'h0000_00b4);
    wait_irq(n);
    chk("conversion time", 1'b1, n >= 28 && n <= 40);
    rd(CTL, 32'h0000_00d4, "done");
    rd(RES, 32'h0000_00ff, "full scale");
    chk("final code", 32'h0000_00ff, {24'h00_0000, dac_code});
    chk("wake", 1'b1, wake_req);
    // Event status: masked, unmasked, cleared
    rd(STS, 32'h0000_0003, "events");
    chk("masked irq", 1'b0, irq);
    wr(MSK, 32'h0000_0001);
    chk("unmasked irq", 1'b1, irq);
    wr(STS, 32'h0000_0001);
    chk("cleared irq", 1'b0, irq);
    rd(STS, 32'h0000_0002, "events left");
    // Restart mid-run; first finish must never show
    @(posedge clk);
    cmp_above_pin <= 1'b0;
    wr(CTL, 32'h0000_00b0);
    chk("request cleared", 1'b0, conv_irq);
    chk("first trial", 32'h0000_0080, {24'h00_0000, dac_code});
    chk("osc enabled", 1'b0, main_osc_disable);
    rd(CTL, 32'h0000_0090, "busy");
    wr(CTL, 32'h0000_00b0);
    wait_irq(n);
    chk("restart time", 1'b1, n >= 28 && n <= 40);
    rd(RES, 32'h0000_0000, "zero scale");
    wr(CTL, 32'h0000_0010);
    chk("gated", 1'b0, conv_irq);
    rd(CTL, 32'h0000_0050, "done kept");
    // Stop: off, no wake, start refused
    @(posedge clk);
    stop_mode_pin <= 1'b1;
    wr(CTL, 32'h0000_0090);
    chk("stop power", 1'b0, converter_power_on);
    chk("stop wake", 1'b0, wake_req);
    wr(CTL, 32'h0000_00b0);
    rd(CTL, 32'h0000_00d0, "stop start");
    @(posedge clk);
    stop_mode_pin <= 1'b0;
    repeat (6) @(negedge clk);
    chk("wait wake", 1'b1, wake_req);
    // Powered off: start refused too
    wr(CTL, 32'h0000_0000);
    chk("off", 1'b0, converter_power_on);
    wr(CTL, 32'h0000_0020);
    rd(CTL, 32'h0000_0040, "off start");
    tally_and_finish();
  end
endmodule
`default_nettype wire
